/* File: design/exec_pkg.sv */
// Purpose: shared constants and carriers for the instruction execute block
// Assumes: 14-bit instruction words, 7-bit file address, 13-bit pointer
// Notes: opcode patterns follow the usual mid-range 14-bit encoding
`default_nettype none
package exec_pkg;
   // ----------------------------------------------------------------
   // widths and fields
   // ----------------------------------------------------------------
   localparam int unsigned IW = 14;
   localparam int unsigned FW = 7;
   localparam int unsigned PCW = 13;
   localparam int unsigned KCALLW = 11;
   localparam int unsigned DBIT = 7;
   localparam int unsigned BPOS_LO = 7;
   localparam int unsigned LATCH_HI = 4;
   localparam int unsigned LATCH_LO = 3;
   localparam int unsigned NIBBLE = 4;
   localparam logic [PCW-1:0] RESET_PTR = 13'h0000;
   localparam logic [7:0] RESET_ACC = 8'h00;
   // file addresses of special registers; chosen, not given
   localparam logic [FW-1:0] TIMER_ZERO_ADDR = 7'h01;
   localparam logic [FW-1:0] PORT_LO_ADDR = 7'h05;
   localparam logic [FW-1:0] PORT_HI_ADDR = 7'h07;
   // ----------------------------------------------------------------
   // opcode patterns
   // ----------------------------------------------------------------
   localparam logic [5:0] OP_ADD_FILE = 6'h07;
   localparam logic [5:0] OP_AND_FILE = 6'h05;
   localparam logic [3:0] OP_SET_BIT = 4'h5;
   localparam logic [3:0] OP_SKIP_LOW = 4'h6;
   localparam logic [3:0] OP_SKIP_HIGH = 4'h7;
   localparam logic [5:0] OP_AND_LIT = 6'h39;
   localparam logic [2:0] OP_CALL = 3'h4;

   typedef enum logic [2:0] {
      K_NONE, K_ADD, K_AND_F, K_AND_L, K_SET, K_SKIP_LO, K_SKIP_HI, K_CALL
   } kind_t;

   typedef struct packed {
      logic c;
      logic half_borrow;
      logic z;
   } flags_t;

   typedef struct packed {
      logic en;
      logic [FW-1:0] addr;
      logic [7:0] data;
   } file_wr_t;
endpackage : exec_pkg
`default_nettype wire

/* File: design/core_instruction_execute.sv */
// Purpose: execute add, and, bit set, bit test skip and call
// Assumes: one instruction per clock enable; file read is combinational
// Notes: other instructions retire as a plain single cycle
// Contract
// RL1 - add accumulator to file, choose destination
// RL2 - set one file bit, flags untouched
// RL3 - and literal into accumulator, zero only
// RL4 - and accumulator with file, zero only
// RL5 - skip next when tested bit is zero
// RL6 - skip next when tested bit is one
// RL7 - call pushes return, loads target and latch
// RL8 - call takes two cycles, no flags
// RL9 - port read-modify-write sources the pins
// RL10 - writing timer count clears its prescaler; the code clears it only while prescaler_to_timer is set
// RL11 - carry, half carry and zero on add
`default_nettype none
module core_instruction_execute (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [exec_pkg::IW-1:0] instr,
   input wire logic instr_valid,
   input wire logic [7:0] file_rdata,
   input wire logic [7:0] pin_rdata,
   input wire logic [4:0] upper_pointer_latch,
   input wire logic prescaler_to_timer,
   output logic [exec_pkg::FW-1:0] file_raddr,
   output exec_pkg::file_wr_t file_wr,
   output logic [7:0] acc,
   output exec_pkg::flags_t flags,
   output logic [exec_pkg::PCW-1:0] program_counter,
   output logic push_valid,
   output logic [exec_pkg::PCW-1:0] stack_top,
   output logic prescaler_clear,
   output logic instr_ready
);
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic exec_pkg::kind_t decode(
      input logic [exec_pkg::IW-1:0] w);
      decode = exec_pkg::K_NONE;
      if (w[13:8] == exec_pkg::OP_ADD_FILE) decode = exec_pkg::K_ADD;
      else if (w[13:8] == exec_pkg::OP_AND_FILE) decode = exec_pkg::K_AND_F;
      else if (w[13:8] == exec_pkg::OP_AND_LIT) decode = exec_pkg::K_AND_L;
      else if (w[13:10] == exec_pkg::OP_SET_BIT) decode = exec_pkg::K_SET;
      else if (w[13:10] == exec_pkg::OP_SKIP_LOW)
         decode = exec_pkg::K_SKIP_LO;
      else if (w[13:10] == exec_pkg::OP_SKIP_HIGH)
         decode = exec_pkg::K_SKIP_HI;
      else if (w[13:11] == exec_pkg::OP_CALL) decode = exec_pkg::K_CALL;
   endfunction : decode

   function automatic logic is_port(input logic [exec_pkg::FW-1:0] a);
      is_port = (a >= exec_pkg::PORT_LO_ADDR) &&
         (a <= exec_pkg::PORT_HI_ADDR);
   endfunction : is_port

   // a taken skip or a call spends its second cycle in one of the no-op states
   typedef enum logic [1:0] {S_RUN, S_SKIP_NOP, S_CALL_NOP} state_t;

   state_t state_q, state_d;
   logic [7:0] acc_q, acc_d;
   exec_pkg::flags_t flags_q, flags_d;
   logic [exec_pkg::PCW-1:0] ptr_q, ptr_d;
   exec_pkg::file_wr_t wr_q, wr_d;
   logic push_q, push_d;
   logic [exec_pkg::PCW-1:0] ret_q, ret_d;
   logic pclr_q, pclr_d;
   logic [7:0] pin_meta_q, pin_sync_q;

   exec_pkg::kind_t kind;
   logic [exec_pkg::FW-1:0] faddr;
   logic [2:0] bpos;
   logic to_file;
   logic [7:0] src;
   logic [8:0] sum;
   logic [4:0] half;
   logic [7:0] res;
   logic tested;

   assign kind = decode(instr);
   assign faddr = instr[exec_pkg::FW-1:0];
   assign bpos = instr[exec_pkg::BPOS_LO+2:exec_pkg::BPOS_LO];
   assign to_file = instr[exec_pkg::DBIT];
   assign file_raddr = faddr;
   assign src = is_port(faddr) ? pin_sync_q : file_rdata; // RL9
   assign tested = src[bpos];

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   // pins move with no regard to this clock, so their levels pass two
   // flip-flops first; the addressed port must hold its pins for two
   // clocks before a word that reads it back
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= pin_rdata;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      acc_d = acc_q;
      flags_d = flags_q;
      ptr_d = ptr_q;
      wr_d = '0;
      push_d = 1'b0;
      ret_d = ret_q;
      pclr_d = 1'b0;
      sum = {1'b0, acc_q} + {1'b0, src};
      half = {1'b0, acc_q[exec_pkg::NIBBLE-1:0]} +
         {1'b0, src[exec_pkg::NIBBLE-1:0]};
      res = '0;
      unique case (state_q)
         S_SKIP_NOP: begin
            // the skipped word is dropped but still costs its slot
            state_d = S_RUN; // RL5 RL6
            ptr_d = ptr_q + 13'h0001;
         end
         S_CALL_NOP: begin
            // target already loaded; the pointer holds for this cycle
            state_d = S_RUN; // RL8
         end
         S_RUN: begin
            if (instr_valid) begin
               ptr_d = ptr_q + 13'h0001;
               unique case (kind)
                  exec_pkg::K_ADD: begin
                     res = sum[7:0]; // RL1
                     flags_d.c = sum[8]; // RL11
                     flags_d.half_borrow = half[exec_pkg::NIBBLE]; // RL11
                     flags_d.z = (res == 8'h00); // RL11
                  end
                  exec_pkg::K_AND_F: begin
                     res = acc_q & src; // RL4
                     flags_d.z = (res == 8'h00); // RL4
                  end
                  exec_pkg::K_AND_L: begin
                     res = acc_q & instr[7:0]; // RL3
                     flags_d.z = (res == 8'h00); // RL3
                     acc_d = res; // RL3
                  end
                  exec_pkg::K_SET: begin
                     res = src | (8'h01 << bpos); // RL2
                     wr_d = '{en: 1'b1, addr: faddr, data: res}; // RL2
                  end
                  exec_pkg::K_SKIP_LO: begin
                     if (!tested) state_d = S_SKIP_NOP; // RL5
                  end
                  exec_pkg::K_SKIP_HI: begin
                     if (tested) state_d = S_SKIP_NOP; // RL6
                  end
                  exec_pkg::K_CALL: begin
                     ret_d = ptr_q + 13'h0001; // RL7
                     push_d = 1'b1; // RL7
                     ptr_d = {upper_pointer_latch[exec_pkg::LATCH_HI:
                        exec_pkg::LATCH_LO],
                        instr[exec_pkg::KCALLW-1:0]}; // RL7
                     state_d = S_CALL_NOP; // RL8
                  end
                  exec_pkg::K_NONE: begin
                  end
               endcase
               if (kind == exec_pkg::K_ADD || kind == exec_pkg::K_AND_F) begin
                  if (to_file)
                     wr_d = '{en: 1'b1, addr: faddr, data: res}; // RL1 RL4
                  else
                     acc_d = res; // RL1 RL4
               end
               // timer write also clears its prescaler when assigned
               pclr_d = wr_d.en && wr_d.addr == exec_pkg::TIMER_ZERO_ADDR &&
                  prescaler_to_timer; // RL10
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= S_RUN;
         acc_q <= exec_pkg::RESET_ACC;
         flags_q <= '0;
         ptr_q <= exec_pkg::RESET_PTR;
         wr_q <= '0;
         push_q <= 1'b0;
         ret_q <= '0;
         pclr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         acc_q <= acc_d;
         flags_q <= flags_d;
         ptr_q <= ptr_d;
         wr_q <= wr_d;
         push_q <= push_d;
         ret_q <= ret_d;
         pclr_q <= pclr_d;
      end
   end

   assign acc = acc_q;
   assign flags = flags_q;
   assign program_counter = ptr_q;
   assign file_wr = wr_q;
   // push lasts one cycle; the pushed address stays until the next call
   assign push_valid = push_q;
   assign stack_top = ret_q;
   assign prescaler_clear = pclr_q;
   // fetched word is consumed only in the run state; a no-op discards it
   assign instr_ready = (state_q == S_RUN);
endmodule : core_instruction_execute
`default_nettype wire

/* File: dv/exec_sva.sv */
// Purpose: port checker for the instruction execute block
// Assumes: file addresses 05 to 07 are ports that read the pins
// Notes: attached to every execute block by the bind at the foot
`default_nettype none
module exec_sva (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [13:0] instr,
   input wire logic instr_valid,
   input wire logic [7:0] file_rdata,
   input wire logic [7:0] pin_rdata,
   input wire logic [4:0] upper_pointer_latch,
   input wire logic prescaler_to_timer,
   input wire logic [6:0] file_raddr,
   input wire exec_pkg::file_wr_t file_wr,
   input wire logic [7:0] acc,
   input wire exec_pkg::flags_t flags,
   input wire logic [12:0] program_counter,
   input wire logic push_valid,
   input wire logic [12:0] stack_top,
   input wire logic prescaler_clear,
   input wire logic instr_ready
);
   // ----------
   // conditions
   // ----------
   logic tk, c_call, c_lo, c_hi, c_set, c_lit, c_add, tb;
   logic [7:0] src, pin_meta_q, pin_sync_q;
   // pins reach the block through two flip-flops; mirror that delay here
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= pin_rdata;
         pin_sync_q <= pin_meta_q;
      end
   end
   // port registers must be judged on the pins, not the latch
   assign src = (file_raddr inside {[7'h05:7'h07]}) ? pin_sync_q :
      file_rdata;
   assign tb = src[instr[9:7]];
   assign tk = instr_valid && instr_ready;
   assign c_call = tk && instr[13:11] == 3'h4;
   assign c_lo = tk && instr[13:10] == 4'h6;
   assign c_hi = tk && instr[13:10] == 4'h7;
   assign c_set = tk && instr[13:10] == 4'h5;
   assign c_lit = tk && instr[13:8] == 6'h39;
   assign c_add = tk && instr[13:8] == 6'h07;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   AST_CALL_PC: assert property (c_call |=> program_counter ==
      {$past(upper_pointer_latch[4:3]), $past(instr[10:0])})
      else $error("call target wrong");
   AST_CALL_PUSH: assert property (c_call |=> push_valid &&
      stack_top == $past(program_counter) + 13'h0001) else $error("call push");
   AST_CALL_TWO: assert property (c_call |=> !instr_ready &&
      $stable(flags) ##1 instr_ready) else $error("call length");
   AST_SKIP_LO: assert property (c_lo |=>
      instr_ready == $past(tb)) else $error("skip low");
   AST_SKIP_HI: assert property (c_hi |=>
      instr_ready == !$past(tb) && $stable(flags)) else $error("skip high");
   AST_SET: assert property (c_set |=> file_wr.en && $stable(flags) &&
      file_wr.data == ($past(src) | 8'h01 << $past(instr[9:7])))
      else $error("bit set");
   AST_AND_LIT: assert property (c_lit |=> flags.z == (acc == 8'h00) &&
      acc == ($past(acc) & $past(instr[7:0])) && $stable(flags.c))
      else $error("and literal");
   AST_ADD: assert property (c_add && !instr[7] |=>
      {flags.c, acc} == {1'b0, $past(acc)} + {1'b0, $past(src)})
      else $error("add result");
   AST_TIMER: assert property (file_wr.en && file_wr.addr == 7'h01 |->
      prescaler_clear == $past(prescaler_to_timer)) else $error("prescaler");
   CV_CALL: cover property (c_call ##1 push_valid);
   CV_SKIP: cover property (c_lo ##1 !instr_ready);
   CV_TIMER: cover property (file_wr.en && prescaler_clear);
endmodule : exec_sva
bind core_instruction_execute exec_sva u_sva (.*);
`default_nettype wire

/* File: dv/tb_top.sv */
// Purpose: directed bench for the instruction execute block
// Assumes: file read data is held by the bench for each word
// Notes: the bench tracks the expected pointer itself in epc
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic instr_valid = 1'b0;
   logic [7:0] file_rdata = 8'h00;
   logic [7:0] pin_rdata = 8'h00;
   logic [4:0] upper_pointer_latch = 5'h00;
   logic prescaler_to_timer = 1'b0;
   logic [6:0] file_raddr;
   exec_pkg::file_wr_t file_wr;
   exec_pkg::flags_t flags;
   logic [7:0] acc;
   logic [12:0] program_counter, stack_top;
   logic push_valid, prescaler_clear, instr_ready;
   logic [12:0] epc = 13'h0000;
   int miscompares = 0;
   int compares = 0;
   core_instruction_execute uut (.*);
   initial begin
      forever #5 clock = ~clock;
   end
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task finish_test;
      if (miscompares == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   // drives one word at a falling edge, returns one clock later at the next falling edge
   task ex(input logic [13:0] w, input logic [7:0] f);
      instr = w;
      file_rdata = f;
      instr_valid = 1'b1;
      @(negedge clock);
      epc = epc + 13'h0001;
   endtask : ex
   task t_add;
      prescaler_to_timer = 1'b1;
      ex(14'h0710, 8'hf8);
      cmp(32'(acc), 32'hf8);
      cmp(32'(file_raddr), 32'h10);
      ex(14'h0710, 8'h08);
      cmp(32'({flags, acc}), 32'h700);
      ex(14'h0781, 8'h05);
      cmp(32'(file_wr), 32'h8105);
      cmp(32'({prescaler_clear, acc}), 32'h100);
      prescaler_to_timer = 1'b0;
      ex(14'h0781, 8'h05);
      cmp(32'(prescaler_clear), 32'h0);
   endtask : t_add
   // pin levels are set two words ahead: the block reads them synchronised
   task t_set;
      pin_rdata = 8'h40;
      ex(14'h0710, 8'h00);
      ex(14'h1790, 8'h01);
      cmp(32'({flags, file_wr}), 32'h19081);
      ex(14'h1406, 8'hff);
      cmp(32'(file_wr), 32'h8641);
   endtask : t_set
   task t_and;
      pin_rdata = 8'h5a;
      ex(14'h0710, 8'h3c);
      ex(14'h0710, 8'hf0);
      ex(14'h39d3, 8'hff);
      cmp(32'({flags, acc}), 32'h500);
      ex(14'h0710, 8'hff);
      ex(14'h0585, 8'h00);
      cmp(32'({acc, file_wr}), 32'hff855a);
      ex(14'h0510, 8'h0f);
      cmp(32'({flags, acc}), 32'h00f);
   endtask : t_and
   task t_skip;
      ex(14'h1810, 8'hfe);
      cmp(32'(instr_ready), 32'h0);
      ex(14'h0710, 8'h77);
      cmp(32'({instr_ready, acc}), 32'h10f);
      ex(14'h1810, 8'h01);
      cmp(32'(instr_ready), 32'h1);
      ex(14'h1d90, 8'h08);
      cmp(32'(instr_ready), 32'h0);
      ex(14'h0710, 8'h77);
      ex(14'h1d90, 8'hf7);
      cmp(32'({instr_ready, flags, acc}), 32'h80f);
      cmp(32'(program_counter), 32'(epc));
   endtask : t_skip
   task t_call;
      upper_pointer_latch = 5'h0f;
      ex(14'h2555, 8'h00);
      cmp(32'(stack_top), 32'(epc));
      cmp(32'({push_valid, instr_ready, program_counter}), 32'h4d55);
      ex(14'h0710, 8'h33);
      cmp(32'({push_valid, instr_ready, program_counter}), 32'h2d55);
      cmp(32'({flags, acc}), 32'h00f);
   endtask : t_call
   initial begin
      repeat (2) @(negedge clock);
      arst_n = 1'b1;
      t_add;
      t_set;
      t_and;
      t_skip;
      t_call;
      finish_test;
   end
   initial begin
      #5000;
      miscompares++;
      finish_test;
   end
endmodule : tb_top
`default_nettype wire
